// ---- hdl/bus_exc_pkg.sv ----
`default_nettype none
package bus_exc_pkg;

  localparam int unsigned RESET_HOLD_CYCLES = 512;
  localparam int unsigned SYS_RESET_CYCLES = 16;
  localparam int unsigned ACK_DELAY_CYCLES = 2;
  localparam logic LINE_RELEASED = 1'b1;
  localparam logic LINE_ASSERTED = 1'b0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CYCLE,
    ST_RETRY,
    ST_END
  } bus_state_t;

  typedef enum logic [1:0] {
    RST_NONE,
    RST_FULL,
    RST_EXTERNAL_ONLY
  } reset_kind_t;

endpackage
`default_nettype wire

// ---- hdl/bus_exc_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface bus_exc_if;
  // open-drain pins: out, enable per party; level resolved here
  logic dev_rst_o;
  logic dev_rst_oe;
  logic sys_rst_o;
  logic sys_rst_oe;
  logic dev_halt_o;
  logic dev_halt_oe;
  logic sys_halt_o;
  logic sys_halt_oe;
  logic reset_n;
  logic halt_n;
  logic locked_cycle_indicator_n;
  logic cycle_strobe_n;
  logic arb_grant_n;
  logic bus_fault_input_n;
  logic cycle_ack_n;
  logic arb_req_n;

  assign reset_n = !((dev_rst_oe && !dev_rst_o) ||
                     (sys_rst_oe && !sys_rst_o));
  assign halt_n = !((dev_halt_oe && !dev_halt_o) ||
                    (sys_halt_oe && !sys_halt_o));

  modport dev (
    output dev_rst_o, dev_rst_oe, dev_halt_o, dev_halt_oe,
    output locked_cycle_indicator_n, cycle_strobe_n, arb_grant_n,
    input reset_n, halt_n, bus_fault_input_n, cycle_ack_n, arb_req_n
  );

  modport sys (
    output sys_rst_o, sys_rst_oe, sys_halt_o, sys_halt_oe,
    output bus_fault_input_n, cycle_ack_n, arb_req_n,
    input reset_n, halt_n, locked_cycle_indicator_n, cycle_strobe_n,
    input arb_grant_n
  );
endinterface
`default_nettype wire

// ---- hdl/bus_exc_device.sv ----
`timescale 1ns/100ps
`default_nettype none
module bus_exc_device #(
  parameter int unsigned HOLD_CYCLES = bus_exc_pkg::RESET_HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  bus_exc_if.dev bus,
  input wire logic i_cycle_req,
  input wire logic i_locked_seq,
  input wire logic i_reset_instr,
  input wire logic i_integ_reset,
  input wire logic i_double_fault,
  output logic o_cycle_done,
  output logic o_cycle_fault,
  output logic o_cycle_retry,
  output logic o_core_reset,
  output logic o_module_reset,
  output logic o_bus_suspended,
  output logic o_granted,
  output logic o_rst_driving
);
  import bus_exc_pkg::*;

  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);

  if (HOLD_CYCLES < 1) begin : g_hold_check
    $error("HOLD_CYCLES must be at least one");
  end

  bus_state_t state_q;
  bus_state_t state_d;
  reset_kind_t rst_kind_q;
  logic rst_drive_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic halt_drive_q;
  logic lock_n_q;
  logic strobe_n_q;
  logic grant_q;
  logic grant_n_q;
  logic grant_d;
  logic line_low;
  logic halt_low;
  logic fault_low;
  logic ack_low;
  logic arb_low;

  assign line_low = !bus.reset_n;
  assign halt_low = !bus.halt_n;
  assign fault_low = !bus.bus_fault_input_n;
  assign ack_low = !bus.cycle_ack_n;
  assign arb_low = !bus.arb_req_n;

  // open-drain drivers only ever pull low
  assign bus.dev_rst_o = LINE_ASSERTED;
  assign bus.dev_rst_oe = rst_drive_q;
  assign bus.dev_halt_o = LINE_ASSERTED;
  assign bus.dev_halt_oe = halt_drive_q;
  assign bus.locked_cycle_indicator_n = lock_n_q;
  assign bus.cycle_strobe_n = strobe_n_q;
  assign bus.arb_grant_n = grant_n_q;

  // reset line drive, counted hold
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_drive_q <= 1'b0;
      rst_cnt_q <= '0;
      rst_kind_q <= RST_NONE;
    end else if (!rst_drive_q && (i_integ_reset || i_reset_instr)) begin
      rst_drive_q <= 1'b1;
      rst_cnt_q <= CNT_W'(HOLD_CYCLES - 1);
      if (i_integ_reset) begin
        rst_kind_q <= RST_FULL;
      end else begin
        rst_kind_q <= RST_EXTERNAL_ONLY;
      end
    end else if (rst_drive_q) begin
      if (rst_cnt_q == '0) begin
        rst_drive_q <= 1'b0;
        rst_kind_q <= RST_NONE;
      end else begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
      end
    end
  end

  assign o_rst_driving = rst_drive_q;

  // internal reset scope
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_core_reset <= 1'b0;
      o_module_reset <= 1'b0;
    end else begin
      // core stays intact on an instruction-driven reset
      o_core_reset <= line_low && (rst_kind_q != RST_EXTERNAL_ONLY);
      // modules cleared, integration and configuration untouched
      o_module_reset <= line_low;
    end
  end

  // double bus fault signalled on halt
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      halt_drive_q <= 1'b0;
    end else begin
      halt_drive_q <= i_double_fault;
    end
  end

  // lock indicator follows the sequence
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lock_n_q <= LINE_RELEASED;
    end else begin
      lock_n_q <= !i_locked_seq;
    end
  end

  // cycle sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // halt low keeps the bus still; while it is released a request starts a cycle unless the bus is granted away
        if (i_cycle_req && !halt_low && !grant_q) begin
          state_d = ST_CYCLE;
        end
      end
      ST_CYCLE: begin
        if (fault_low && halt_low) begin
          state_d = ST_RETRY;
        end else if (fault_low) begin
          state_d = ST_END;
        end else if (ack_low) begin
          state_d = ST_END;
        end
      end
      ST_RETRY: begin
        if (!halt_low && !fault_low) begin
          state_d = ST_CYCLE;
        end
      end
      ST_END: begin
        if (!ack_low && !fault_low) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (line_low) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      strobe_n_q <= LINE_RELEASED;
    end else begin
      state_q <= state_d;
      strobe_n_q <= (state_d != ST_CYCLE);
    end
  end

  // cycle outcome pulses
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_cycle_done <= 1'b0;
      o_cycle_fault <= 1'b0;
      o_cycle_retry <= 1'b0;
    end else begin
      o_cycle_done <= (state_q == ST_CYCLE) && (state_d == ST_END) &&
                      !fault_low;
      o_cycle_fault <= (state_q == ST_CYCLE) && (state_d == ST_END) &&
                       fault_low;
      o_cycle_retry <= (state_q == ST_CYCLE) && (state_d == ST_RETRY);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_bus_suspended <= 1'b0;
    end else begin
      o_bus_suspended <= halt_low;
    end
  end

  // bus hand-over, never while locked
  always_comb begin
    if (line_low) begin
      grant_d = 1'b0;
    end else if (grant_q) begin
      grant_d = arb_low;
    end else begin
      grant_d = arb_low && (state_q == ST_IDLE) &&
                (state_d == ST_IDLE) && !i_locked_seq;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      grant_q <= 1'b0;
      grant_n_q <= LINE_RELEASED;
      o_granted <= 1'b0;
    end else begin
      grant_q <= grant_d;
      grant_n_q <= !grant_d;
      o_granted <= grant_d;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/bus_exc_system.sv ----
`timescale 1ns/100ps
`default_nettype none
module bus_exc_system #(
  parameter int unsigned RESET_CYCLES = bus_exc_pkg::SYS_RESET_CYCLES,
  parameter int unsigned ACK_DELAY = bus_exc_pkg::ACK_DELAY_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  bus_exc_if.sys bus,
  input wire logic i_reset_req,
  input wire logic i_halt_req,
  input wire logic i_step,
  input wire logic i_fault_req,
  input wire logic i_retry_req,
  input wire logic i_arb_req,
  output logic o_reset_seen,
  output logic o_double_fault,
  output logic o_locked,
  output logic o_granted,
  output logic o_cycle_seen
);
  import bus_exc_pkg::*;

  localparam int unsigned RCNT_W = $clog2(RESET_CYCLES + 1);
  localparam int unsigned ACNT_W = $clog2(ACK_DELAY + 2);

  if (RESET_CYCLES < 1 || ACK_DELAY < 1) begin : g_param_check
    $error("RESET_CYCLES and ACK_DELAY must be at least one");
  end

  logic rst_drive_q;
  logic [RCNT_W-1:0] rst_cnt_q;
  logic [ACNT_W-1:0] wait_cnt_q;
  logic answered_q;
  logic ack_n_q;
  logic fault_n_q;
  logic retry_halt_q;
  logic step_q;
  logic halt_drive_q;
  logic arb_n_q;
  logic strobe_low;
  logic strobe_low_q;
  logic retry_now;

  assign strobe_low = !bus.cycle_strobe_n;
  // halt must fall with the fault, or the device sees a plain abort
  assign retry_now = strobe_low && !answered_q && i_retry_req &&
                     (wait_cnt_q == ACNT_W'(ACK_DELAY - 1));
  assign bus.sys_rst_o = LINE_ASSERTED;
  assign bus.sys_rst_oe = rst_drive_q;
  assign bus.sys_halt_o = LINE_ASSERTED;
  assign bus.sys_halt_oe = halt_drive_q;
  assign bus.cycle_ack_n = ack_n_q;
  assign bus.bus_fault_input_n = fault_n_q;
  assign bus.arb_req_n = arb_n_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_drive_q <= 1'b0;
      rst_cnt_q <= '0;
    end else if (!rst_drive_q && i_reset_req) begin
      rst_drive_q <= 1'b1;
      rst_cnt_q <= RCNT_W'(RESET_CYCLES - 1);
    end else if (rst_drive_q) begin
      if (rst_cnt_q == '0) begin
        rst_drive_q <= 1'b0;
      end else begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
      end
    end
  end

  // answer each cycle after a fixed wait, release on strobe negation
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !strobe_low) begin
      wait_cnt_q <= '0;
      answered_q <= 1'b0;
      ack_n_q <= LINE_RELEASED;
      fault_n_q <= LINE_RELEASED;
      retry_halt_q <= 1'b0;
    end else if (!answered_q) begin
      if (wait_cnt_q == ACNT_W'(ACK_DELAY - 1)) begin
        answered_q <= 1'b1;
        if (i_retry_req) begin
          fault_n_q <= LINE_ASSERTED;
          retry_halt_q <= 1'b1;
        end else if (i_fault_req) begin
          fault_n_q <= LINE_ASSERTED;
        end else begin
          ack_n_q <= LINE_ASSERTED;
        end
      end else begin
        wait_cnt_q <= wait_cnt_q + 1'b1;
      end
    end
  end

  // single step: one cycle may start per step pulse
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      step_q <= 1'b0;
      halt_drive_q <= 1'b0;
      strobe_low_q <= 1'b0;
    end else begin
      strobe_low_q <= strobe_low;
      if (i_step) begin
        step_q <= 1'b1;
      end else if (strobe_low && !strobe_low_q) begin
        step_q <= 1'b0;
      end
      halt_drive_q <= (i_halt_req && !(step_q || i_step)) ||
                      retry_now ||
                      (retry_halt_q && strobe_low);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      arb_n_q <= LINE_RELEASED;
      o_reset_seen <= 1'b0;
      o_double_fault <= 1'b0;
      o_locked <= 1'b0;
      o_granted <= 1'b0;
      o_cycle_seen <= 1'b0;
    end else begin
      arb_n_q <= !i_arb_req;
      o_reset_seen <= !bus.reset_n;
      o_double_fault <= !bus.halt_n && !halt_drive_q;
      o_locked <= !bus.locked_cycle_indicator_n;
      o_granted <= !bus.arb_grant_n;
      o_cycle_seen <= strobe_low && !strobe_low_q;
    end
  end

endmodule
`default_nettype wire

// ---- tb/bus_exc_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module bus_exc_assertions #(
  parameter int unsigned HOLD_CYCLES = bus_exc_pkg::RESET_HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic dev_rst_o,
  input wire logic dev_rst_oe,
  input wire logic dev_halt_o,
  input wire logic dev_halt_oe,
  input wire logic reset_n,
  input wire logic halt_n,
  input wire logic locked_cycle_indicator_n,
  input wire logic cycle_strobe_n,
  input wire logic arb_grant_n,
  input wire logic bus_fault_input_n
);
  logic [15:0] hold_q;
  // cycles the device has pulled reset so far
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !dev_rst_oe) begin
      hold_q <= 16'h0000;
    end else begin
      hold_q <= hold_q + 16'h0001;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_busy;
    !cycle_strobe_n;
  endsequence
  sequence s_retry;
    s_busy ##0 (!bus_fault_input_n && !halt_n);
  endsequence
  sequence s_abort;
    s_busy ##0 (!bus_fault_input_n && halt_n);
  endsequence
  a_lock_no_grant: assert property (
    $fell(arb_grant_n) |-> locked_cycle_indicator_n)
    else $error("bus granted during locked sequence");
  a_rst_hold_len: assert property (
    $fell(dev_rst_oe) |-> hold_q == 16'(HOLD_CYCLES))
    else $error("reset drive length wrong");
  a_rst_pull_low: assert property (
    dev_rst_oe |-> !dev_rst_o && !reset_n)
    else $error("reset drive not pulling line low");
  a_ext_rst_abort: assert property (
    !reset_n && !dev_rst_oe |=> cycle_strobe_n)
    else $error("cycle kept running in outside reset");
  a_halt_no_start: assert property (
    $fell(cycle_strobe_n) |-> $past(halt_n))
    else $error("cycle started while halted");
  a_retry_rerun: assert property (
    s_retry |=> cycle_strobe_n ##[1:40] !cycle_strobe_n)
    else $error("retry did not rerun cycle");
  a_fault_abort: assert property (
    s_abort |=> cycle_strobe_n [*3])
    else $error("faulted cycle not aborted");
  a_halt_drive: assert property (
    dev_halt_oe |-> !dev_halt_o && !halt_n)
    else $error("halt drive not pulling line low");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bus_exc_pkg::*;
  localparam int unsigned HOLD = 8;
  logic i_clk, i_sys_rst, cycle_req, locked_seq, reset_instr, integ_reset;
  logic double_fault, reset_req, halt_req, step, fault_req, retry_req;
  logic arb_req, cycle_done, cycle_fault, cycle_retry, core_reset;
  logic module_reset, bus_suspended, dev_granted, rst_driving, reset_seen;
  logic double_seen, locked, sys_granted, cycle_seen;
  int err_total, num_checks;
  // 0 rst drive,1 core rst,2 module rst,3 done,4 fault,5 retry,6 grant,7 strobe
  // 8 reset seen by system, 9 device reset drive flag
  int cnt[10];
  bus_exc_if bus ();
  bus_exc_device #(.HOLD_CYCLES(HOLD)) bus_exc_device_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus.dev),
    .i_cycle_req(cycle_req), .i_locked_seq(locked_seq),
    .i_reset_instr(reset_instr), .i_integ_reset(integ_reset),
    .i_double_fault(double_fault), .o_cycle_done(cycle_done),
    .o_cycle_fault(cycle_fault), .o_cycle_retry(cycle_retry),
    .o_core_reset(core_reset), .o_module_reset(module_reset),
    .o_bus_suspended(bus_suspended), .o_granted(dev_granted),
    .o_rst_driving(rst_driving));
  bus_exc_system #(.RESET_CYCLES(16), .ACK_DELAY(2)) bus_exc_system_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus.sys),
    .i_reset_req(reset_req), .i_halt_req(halt_req), .i_step(step),
    .i_fault_req(fault_req), .i_retry_req(retry_req), .i_arb_req(arb_req),
    .o_reset_seen(reset_seen), .o_double_fault(double_seen),
    .o_locked(locked), .o_granted(sys_granted), .o_cycle_seen(cycle_seen));
  bus_exc_assertions #(.HOLD_CYCLES(HOLD)) bus_exc_assertions_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .dev_rst_o(bus.dev_rst_o),
    .dev_rst_oe(bus.dev_rst_oe), .dev_halt_o(bus.dev_halt_o),
    .dev_halt_oe(bus.dev_halt_oe), .reset_n(bus.reset_n),
    .halt_n(bus.halt_n), .cycle_strobe_n(bus.cycle_strobe_n),
    .locked_cycle_indicator_n(bus.locked_cycle_indicator_n),
    .arb_grant_n(bus.arb_grant_n),
    .bus_fault_input_n(bus.bus_fault_input_n));
  always @(posedge i_clk) begin
    cnt[0] += int'(bus.dev_rst_oe === 1'b1);
    cnt[1] += int'(core_reset === 1'b1);
    cnt[2] += int'(module_reset === 1'b1);
    cnt[3] += int'(cycle_done === 1'b1);
    cnt[4] += int'(cycle_fault === 1'b1);
    cnt[5] += int'(cycle_retry === 1'b1);
    cnt[6] += int'(dev_granted === 1'b1);
    cnt[7] += int'(cycle_seen === 1'b1);
    cnt[8] += int'(reset_seen === 1'b1);
    cnt[9] += int'(rst_driving === 1'b1);
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic do_cycle();
    int k;
    k = 0;
    cycle_req = 1'b1;
    while (cycle_done !== 1'b1 && cycle_fault !== 1'b1 && k < 60) begin
      @(negedge i_clk);
      // one retry, then let the rerun finish
      if (cycle_retry === 1'b1) retry_req = 1'b0;
      k++;
    end
    cycle_req = 1'b0;
    idle(5);
  endtask
  task automatic t_bus();
    cnt = '{default: 0};
    do_cycle();
    check(cnt[3], 1);
    cnt = '{default: 0};
    fault_req = 1'b1;
    do_cycle();
    fault_req = 1'b0;
    check(cnt[4], 1);
    check(cnt[3], 0);
    cnt = '{default: 0};
    retry_req = 1'b1;
    do_cycle();
    check(cnt[5], 1);
    check(cnt[7], 2);
    $display("bus cycle test done");
  endtask
  task automatic t_lock();
    cnt = '{default: 0};
    locked_seq = 1'b1;
    arb_req = 1'b1;
    do_cycle();
    do_cycle();
    check(cnt[6], 0);
    check(locked, 1'b1);
    locked_seq = 1'b0;
    idle(6);
    check(dev_granted, 1'b1);
    check(sys_granted, 1'b1);
    arb_req = 1'b0;
    idle(4);
    $display("locked sequence test done");
  endtask
  task automatic t_halt();
    cnt = '{default: 0};
    halt_req = 1'b1;
    idle(3);
    cycle_req = 1'b1;
    idle(20);
    check(cnt[7], 0);
    check(bus_suspended, 1'b1);
    step = 1'b1;
    idle(1);
    step = 1'b0;
    do_cycle();
    check(cnt[3], 1);
    check(cnt[7], 1);
    halt_req = 1'b0;
    idle(4);
    $display("halt test done");
  endtask
  task automatic t_rst(input logic [2:0] src, input int oe, input logic core);
    cnt = '{default: 0};
    {reset_instr, integ_reset, reset_req} = src;
    idle(1);
    {reset_instr, integ_reset, reset_req} = 3'b000;
    idle(40);
    check(cnt[0], oe);
    check(cnt[1] > 0, core);
    check(cnt[2] > 0, 1'b1);
    check(cnt[8] > 0, 1'b1);
    check(cnt[9], oe);
    $display("reset test done");
  endtask
  task automatic t_dbl();
    double_fault = 1'b1;
    idle(4);
    check(bus.halt_n, 1'b0);
    check(double_seen, 1'b1);
    double_fault = 1'b0;
    idle(4);
    check(bus.halt_n, 1'b1);
    $display("double fault test done");
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #50000;
    err_total++;
    final_report();
  end
  initial begin
    err_total = 0;
    num_checks = 0;
    cnt = '{default: 0};
    i_sys_rst = 1'b1;
    {cycle_req, locked_seq, reset_instr, integ_reset, double_fault} = '0;
    {reset_req, halt_req, step, fault_req, retry_req, arb_req} = '0;
    repeat (2) @(negedge i_clk);
    i_sys_rst = 1'b0;
    t_bus();
    t_lock();
    t_halt();
    t_rst(3'b100, HOLD, 1'b0);
    t_rst(3'b010, HOLD, 1'b1);
    t_rst(3'b001, 0, 1'b1);
    t_dbl();
    final_report();
  end
endmodule
`default_nettype wire
